// [include/tio_pkg.sv]
// Shared constants for the timed I/O port and clock block logic.
package tio_pkg;
	// Port set and data widths.
	localparam int NPORT = 5;
	localparam int NCB   = 6;
	localparam int DW    = 32;
	localparam int CW    = 16;
	localparam int PORT_W [NPORT] = '{1, 4, 8, 16, 32};
	localparam int CB_SEL_W = 3;
	localparam int SLOT_W   = 6;

	// Reference tick for clock block zero: fractional step of MHz figures.
	localparam int REF_HZ   = 250_000_000;
	localparam int CB0_HZ   = 100_000_000;
	localparam int MHZ      = 1_000_000;
	localparam logic [8:0] CB0_STEP = 9'(CB0_HZ / MHZ);
	localparam logic [8:0] CB0_MOD  = 9'(REF_HZ / MHZ);

	// Register map, byte addresses on an 8-bit word-aligned space.
	localparam int AW = 8;
	localparam logic [AW-1:0] PORT_LIMIT  = 8'ha0;
	localparam logic [4:0]    R_CTRL      = 5'h00;
	localparam logic [4:0]    R_DATA      = 5'h04;
	localparam logic [4:0]    R_TIME      = 5'h08;
	localparam logic [4:0]    R_COUNT     = 5'h0c;
	localparam logic [4:0]    R_STAMP     = 5'h10;
	localparam logic [4:0]    R_COND      = 5'h14;
	localparam logic [AW-1:0] CB_BASE     = 8'hc0;
	localparam logic [AW-1:0] CB_LIMIT    = 8'hd8;
	localparam logic [AW-1:0] IRQ_STAT    = 8'he0;
	localparam logic [AW-1:0] IRQ_CLR     = 8'he4;
	localparam logic [AW-1:0] IRQ_EN      = 8'he8;

	// Port control fields.
	localparam int C_EN   = 0;
	localparam int C_OUT  = 1;
	localparam int C_OD   = 2;
	localparam int C_CM0  = 3;
	localparam int C_SIN  = 5;
	localparam int C_SOUT = 6;
	localparam int C_CLK0 = 8;
	localparam logic [1:0] CM_NONE = 2'h0;
	localparam logic [1:0] CM_EQ   = 2'h1;
	localparam logic [1:0] CM_NE   = 2'h2;

	// Clock block fields: source select and divide.
	localparam int CB_SRC  = 0;
	localparam int CB_DIV0 = 8;
	localparam int DIV_W   = 8;

	// Interrupt layout: done bits then overrun bits.
	localparam int NIRQ = 2 * NPORT;

	// Pins shared with the inter-chip link.
	localparam int LINK_LO = 8;
	localparam int LINK_HI = 15;
endpackage

// [hdl/timed_io.sv]
// Timed I/O ports with serializer, counters, pin sharing and clock blocks.
// Operation
// - Ports of 1,4,8,16,32 bits on pins.
// - A port is wholly input or output.
// - Drive or sample pins, optional wait condition.
// - Each port access completes after one wait cycle.
// - Open-drain: zero pulls low, one releases.
// - Data passes serializer and transfer register.
// - Sixteen-bit counter gates and defers transfers.
// - Each transfer captures counter as timestamp.
// - Enabled link releases port drive on its pins.
// - Narrower enabled port wins shared pins.
// - Port always transfers at its own width.
// - Six clock blocks, first is reference.
// - Clock block may take a 1-bit port.
// - Port-fed clock block optionally divides input.
// - Accept ready-in, generate strobe_out with data.
// - Reset attaches every port to block zero.
// - Pin events go straight to scheduler.
// - Pull-downs enabled while held in reset.
module timed_io
	import tio_pkg::*;
(
	input  wire logic           ref_clk,
	input  wire logic           rstn,
	input  wire logic [AW-1:0]  avs_address,
	input  wire logic           avs_read,
	input  wire logic           avs_write,
	input  wire logic [DW-1:0]  avs_writedata,
	output logic      [DW-1:0]  avs_readdata,
	output logic                avs_waitrequest,
	input  wire logic [DW-1:0]  pin_i,
	output logic      [DW-1:0]  pin_o,
	output logic      [DW-1:0]  pin_oe,
	output logic                pull_dn_en,
	input  wire logic [NPORT-1:0] strobe_in_i,
	output logic      [NPORT-1:0] strobe_out,
	input  wire logic           link_en,
	output logic      [NPORT-1:0] port_event,
	output logic                irq
);
	// Synchronisers: first stage is read only by the second.
	logic [DW-1:0]    pin_m, pin_s;   // Pin samples.
	logic [NPORT-1:0] sin_m, sin_s;   // Ready-in strobes.
	logic             link_m, link_s; // Link enable level.
	logic             pin0_d;         // Previous pin 0 for edge detect.

	// Bus handshake state.
	logic             done_q;         // Second cycle of an access.
	logic [DW-1:0]    rdata_q;        // Registered read data.
	logic [DW-1:0]    rdata_d;        // Read data mux.
	logic             wr_go, rd_go;   // Access takes effect this edge.

	// Port state, one element per port.
	logic [DW-1:0]     ctrl_q  [NPORT]; // Control word.
	logic [DW-1:0]     tx_q    [NPORT]; // Output transfer register.
	logic [DW-1:0]     rx_q    [NPORT]; // Input transfer register.
	logic [DW-1:0]     shift_q [NPORT]; // Serializer.
	logic [DW-1:0]     out_q   [NPORT]; // Value driven by the port.
	logic [DW-1:0]     cond_q  [NPORT]; // Wait condition value.
	logic [CW-1:0]     cnt_q   [NPORT]; // Port counter.
	logic [CW-1:0]     time_q  [NPORT]; // Deferred transfer count.
	logic [CW-1:0]     stamp_q [NPORT]; // Timestamp of last transfer.
	logic [NPORT-1:0]  tx_full_q, rx_full_q, timed_q, busy_q;
	logic [NPORT-1:0]  tick, evt_done, evt_ovr;
	logic [NPORT-1:0]  wr_ctrl, wr_data, wr_time, wr_cond, rd_data;

	// Clock blocks.
	logic [DW-1:0]     cb_cfg_q [NCB]; // Source and divide setting.
	logic [NCB-1:0]    cb_tick;        // One-cycle tick per block.
	logic [8:0]        acc_q;          // Fractional reference phase.

	// Interrupts and pins.
	logic [NIRQ-1:0]   stat_q, en_q;
	logic              pd_q;
	logic [DW-1:0]     pin_o_d, pin_oe_d;

	// Two-flop synchronisers for the pins, the ready-in strobes and the link enable.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_m  <= '0;
			pin_s  <= '0;
			sin_m  <= '0;
			sin_s  <= '0;
			link_m <= 1'b0;
			link_s <= 1'b0;
			pin0_d <= 1'b0;
		end
		else
		begin
			pin_m  <= pin_i;
			pin_s  <= pin_m;
			sin_m  <= strobe_in_i;
			sin_s  <= sin_m;
			link_m <= link_en;
			link_s <= link_m;
			pin0_d <= pin_s[0];
		end
	end

	// Pull-downs stay on while reset holds and drop after release.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			pd_q <= 1'b1;
		else
			pd_q <= 1'b0;
	end
	assign pull_dn_en = pd_q;

	// Every access holds one wait cycle, so reads come from a flop.
	assign avs_waitrequest = (avs_read | avs_write) & ~done_q;
	assign wr_go = avs_write & done_q;
	assign rd_go = avs_read & done_q;
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			done_q  <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			done_q <= (avs_read | avs_write) & ~done_q;
			if (avs_read & ~done_q)
				rdata_q <= rdata_d;
		end
	end
	assign avs_readdata = rdata_q;

	// Read mux; unmapped addresses read as zero.
	always_comb
	begin
		rdata_d = '0;
		if (avs_address < PORT_LIMIT)
		begin
			for (int p = 0; p < NPORT; p++)
			begin
				if (avs_address[7:5] == 3'(p))
				begin
					case (avs_address[4:0])
						R_CTRL:  rdata_d = ctrl_q[p];
						R_DATA:  rdata_d = rx_q[p];
						R_TIME:  rdata_d = DW'(time_q[p]);
						R_COUNT: rdata_d = DW'(cnt_q[p]);
						R_STAMP: rdata_d = DW'(stamp_q[p]);
						R_COND:  rdata_d = cond_q[p];
						default: rdata_d = '0;
					endcase
				end
			end
		end
		else if (avs_address >= CB_BASE && avs_address < CB_LIMIT)
			rdata_d = cb_cfg_q[avs_address[4:2]];
		else if (avs_address == IRQ_STAT)
			rdata_d = DW'(stat_q);
		else if (avs_address == IRQ_EN)
			rdata_d = DW'(en_q);
	end

	// Block zero ticks at 100 MHz on average from the 250 MHz clock.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			acc_q      <= '0;
			cb_tick[0] <= 1'b0;
		end
		else if (acc_q + CB0_STEP >= CB0_MOD)
		begin
			acc_q      <= acc_q + CB0_STEP - CB0_MOD;
			cb_tick[0] <= 1'b1;
		end
		else
		begin
			acc_q      <= acc_q + CB0_STEP;
			cb_tick[0] <= 1'b0;
		end
	end
	assign cb_cfg_q[0] = '0;

	// Programmable blocks: reference or pin 0 rising edge, then divide.
	for (genvar i = 1; i < NCB; i++)
	begin : g_cb
		logic [DIV_W-1:0] div_q; // Source events since last tick.
		logic             src;   // Source event this cycle.
		assign src = cb_cfg_q[i][CB_SRC] ? (pin_s[0] & ~pin0_d)
			: cb_tick[0];
		always_ff @(posedge ref_clk or negedge rstn)
		begin
			if (!rstn)
			begin
				cb_cfg_q[i] <= '0;
				div_q       <= '0;
				cb_tick[i]  <= 1'b0;
			end
			else
			begin
				if (wr_go && avs_address == CB_BASE + AW'(4 * i))
					cb_cfg_q[i] <= avs_writedata;
				cb_tick[i] <= 1'b0;
				// A divide of zero passes every source event through.
				if (src)
				begin
					if (div_q >= cb_cfg_q[i][CB_DIV0 +: DIV_W])
					begin
						div_q      <= '0;
						cb_tick[i] <= 1'b1;
					end
					else
						div_q <= div_q + 1'b1;
				end
			end
		end
	end

	// One port per width; the serializer spans 32 bits at every width.
	for (genvar g = 0; g < NPORT; g++)
	begin : g_port
		localparam int W = PORT_W[g];
		localparam logic [SLOT_W-1:0] LAST = SLOT_W'(DW / W - 1);
		logic [SLOT_W-1:0] slot_q; // Lanes moved in this word.
		logic [W-1:0]      smp;    // Sampled pins at port width.
		logic [DW-1:0]     nxt_in; // Serializer after one input lane.
		logic              go, cok, tok, sok, ld, mv;
		logic [CB_SEL_W-1:0] sel;

		logic base; // Address falls in this port's window.
		assign base = avs_address[7:5] == 3'(g) && avs_address < PORT_LIMIT;
		assign wr_ctrl[g] = wr_go & base & avs_address[4:0] == R_CTRL;
		assign wr_data[g] = wr_go & base & avs_address[4:0] == R_DATA;
		assign wr_time[g] = wr_go & base & avs_address[4:0] == R_TIME;
		assign wr_cond[g] = wr_go & base & avs_address[4:0] == R_COND;
		assign rd_data[g] = rd_go & base & avs_address[4:0] == R_DATA;

		// Tick of the attached block; unknown selections fall to zero.
		assign sel = ctrl_q[g][C_CLK0 +: CB_SEL_W];
		assign tick[g] = (sel < CB_SEL_W'(NCB)) ? cb_tick[sel] : cb_tick[0];

		// Port samples its full width even on pins it does not own.
		assign smp = pin_s[W-1:0];
		assign nxt_in = (shift_q[g] >> W) | (DW'(smp) << (DW - W));
		assign tok = ~timed_q[g] | (cnt_q[g] == time_q[g]);
		assign sok = ~ctrl_q[g][C_SIN] | sin_s[g];
		always_comb
		begin
			case (ctrl_q[g][C_CM0 +: 2])
				CM_EQ:   cok = smp == cond_q[g][W-1:0];
				CM_NE:   cok = smp != cond_q[g][W-1:0];
				default: cok = 1'b1;
			endcase
		end
		assign go = tick[g] & ctrl_q[g][C_EN] & sok;
		// Output: load a new word when idle or on the last lane.
		assign ld = go & ctrl_q[g][C_OUT] & tx_full_q[g] & tok
			& (~busy_q[g] | slot_q == LAST);
		assign mv = go & ctrl_q[g][C_OUT] & busy_q[g] & ~ld;

		// Counter runs on its block's tick and wraps naturally.
		always_ff @(posedge ref_clk or negedge rstn)
		begin
			if (!rstn)
				cnt_q[g] <= '0;
			else if (tick[g])
				cnt_q[g] <= cnt_q[g] + 1'b1;
		end

		// Software-owned settings; reset picks block zero.
		always_ff @(posedge ref_clk or negedge rstn)
		begin
			if (!rstn)
			begin
				ctrl_q[g] <= '0;
				cond_q[g] <= '0;
			end
			else
			begin
				if (wr_ctrl[g])
					ctrl_q[g] <= avs_writedata;
				if (wr_cond[g])
					cond_q[g] <= avs_writedata;
			end
		end

		// Serializer and transfer registers; direction is port-wide.
		always_ff @(posedge ref_clk or negedge rstn)
		begin
			if (!rstn)
			begin
				tx_q[g]      <= '0;
				rx_q[g]      <= '0;
				shift_q[g]   <= '0;
				out_q[g]     <= '0;
				time_q[g]    <= '0;
				stamp_q[g]   <= '0;
				slot_q       <= '0;
				tx_full_q[g] <= 1'b0;
				rx_full_q[g] <= 1'b0;
				timed_q[g]   <= 1'b0;
				busy_q[g]    <= 1'b0;
				evt_done[g]  <= 1'b0;
				evt_ovr[g]   <= 1'b0;
				strobe_out[g] <= 1'b0;
			end
			else
			begin
				evt_done[g]   <= 1'b0;
				evt_ovr[g]    <= wr_data[g] & tx_full_q[g];
				strobe_out[g] <= 1'b0;
				if (wr_time[g])
				begin
					time_q[g]  <= avs_writedata[CW-1:0];
					timed_q[g] <= 1'b1;
				end
				if (rd_data[g])
					rx_full_q[g] <= 1'b0;
				if (wr_data[g])
				begin
					tx_q[g]      <= avs_writedata;
					tx_full_q[g] <= 1'b1;
				end
				if (ld)
				begin
					// The write above cannot be lost: the load frees it.
					out_q[g]      <= tx_q[g];
					shift_q[g]    <= tx_q[g] >> W;
					slot_q        <= '0;
					busy_q[g]     <= LAST != '0;
					tx_full_q[g]  <= wr_data[g];
					timed_q[g]    <= 1'b0;
					stamp_q[g]    <= cnt_q[g];
					evt_done[g]   <= 1'b1;
					strobe_out[g] <= ctrl_q[g][C_SOUT];
				end
				else if (mv)
				begin
					out_q[g]      <= shift_q[g];
					shift_q[g]    <= shift_q[g] >> W;
					slot_q        <= slot_q + 1'b1;
					busy_q[g]     <= slot_q + 1'b1 != LAST;
					strobe_out[g] <= ctrl_q[g][C_SOUT];
				end
				else if (go & ~ctrl_q[g][C_OUT] & cok & tok)
				begin
					// Input: one lane per tick while the condition holds.
					shift_q[g] <= nxt_in;
					if (slot_q == LAST)
					begin
						rx_q[g]      <= nxt_in;
						rx_full_q[g] <= 1'b1;
						evt_ovr[g]   <= rx_full_q[g] & ~rd_data[g];
						slot_q       <= '0;
						timed_q[g]   <= 1'b0;
						stamp_q[g]   <= cnt_q[g];
						evt_done[g]  <= 1'b1;
					end
					else
						slot_q <= slot_q + 1'b1;
				end
			end
		end
	end

	// Completion goes straight to the scheduler as a pulse.
	assign port_event = evt_done;

	// Pin ownership: narrowest enabled port wins, link beats all.
	always_comb
	begin
		pin_o_d  = '0;
		pin_oe_d = '0;
		for (int j = 0; j < DW; j++)
		begin
			for (int p = NPORT - 1; p >= 0; p--)
			begin
				if (ctrl_q[p][C_EN] && j < PORT_W[p])
				begin
					// Later, narrower ports overwrite wider ones.
					pin_o_d[j]  = ctrl_q[p][C_OD] ? 1'b0 : out_q[p][j];
					pin_oe_d[j] = ctrl_q[p][C_OUT]
						& ~(ctrl_q[p][C_OD] & out_q[p][j]);
				end
			end
			if (link_s && j >= LINK_LO && j <= LINK_HI)
			begin
				pin_o_d[j]  = 1'b0;
				pin_oe_d[j] = 1'b0;
			end
		end
	end

	// Pin drive comes from flops; released while pull-downs hold.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_o  <= '0;
			pin_oe <= '0;
		end
		else
		begin
			pin_o  <= pin_o_d;
			pin_oe <= pin_oe_d;
		end
	end

	// Sticky status: a new event beats a clear in the same cycle.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stat_q <= '0;
			en_q   <= '0;
		end
		else
		begin
			if (wr_go && avs_address == IRQ_EN)
				en_q <= avs_writedata[NIRQ-1:0];
			if (wr_go && avs_address == IRQ_CLR)
				stat_q <= (stat_q & ~avs_writedata[NIRQ-1:0])
					| {evt_ovr, evt_done};
			else
				stat_q <= stat_q | {evt_ovr, evt_done};
		end
	end
	assign irq = |(stat_q & en_q);

	// Access sequence: wait one cycle, then complete.
	sequence s_req;
		(avs_read | avs_write) && !done_q;
	endsequence
	sequence s_done;
		!avs_waitrequest;
	endsequence
	property p_access;
		@(posedge ref_clk) disable iff (!rstn)
		s_req |-> avs_waitrequest ##1 s_done;
	endproperty
	a_access: assert property (p_access)
		else $error("access did not complete after one wait");

	property p_pulldown;
		@(posedge ref_clk) disable iff (!rstn)
		$rose(rstn) |-> ##1 !pull_dn_en;
	endproperty
	a_pulldown: assert property (p_pulldown)
		else $error("pull-down still on after reset");

	property p_link;
		@(posedge ref_clk) disable iff (!rstn)
		link_s |-> ##1 (pin_oe[LINK_HI:LINK_LO] == '0);
	endproperty
	a_link: assert property (p_link)
		else $error("port drives a link pin");

	// Pin one is shared only with wider ports, which the nibble port beats, so it shows the port's own
	// open-drain behaviour without a narrower port in the way.
	property p_od;
		@(posedge ref_clk) disable iff (!rstn)
		ctrl_q[1][C_EN] && ctrl_q[1][C_OD] && ctrl_q[1][C_OUT]
			|-> ##1 (pin_oe[1] == !$past(out_q[1][1])) && !pin_o[1];
	endproperty
	a_od: assert property (p_od)
		else $error("open-drain pin wrongly driven");

	property p_count;
		@(posedge ref_clk) disable iff (!rstn)
		tick[1] |=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001;
	endproperty
	a_count: assert property (p_count)
		else $error("port counter did not advance");

	property p_stamp;
		@(posedge ref_clk) disable iff (!rstn)
		$rose(evt_done[2]) |-> stamp_q[2] == $past(cnt_q[2]);
	endproperty
	a_stamp: assert property (p_stamp)
		else $error("timestamp not taken from counter");

	property p_prec;
		@(posedge ref_clk) disable iff (!rstn)
		ctrl_q[0][C_EN] && ctrl_q[1][C_EN] && !ctrl_q[0][C_OD]
			|=> pin_o[0] == $past(out_q[0][0]);
	endproperty
	a_prec: assert property (p_prec)
		else $error("wider port took a shared pin");

	property p_cb0;
		@(posedge ref_clk) disable iff (!rstn)
		cb_tick[0] |=> !cb_tick[0]
			##1 (cb_tick[0] or (!cb_tick[0] ##1 cb_tick[0]));
	endproperty
	a_cb0: assert property (p_cb0)
		else $error("reference block tick spacing wrong");

	property p_setwins;
		@(posedge ref_clk) disable iff (!rstn)
		evt_done[0] |=> stat_q[0];
	endproperty
	a_setwins: assert property (p_setwins)
		else $error("event lost against clear");
endmodule

// [verif/pin_partner.sv]
// Behavioural model of the hardware that sits on the device pins.
module pin_partner
	import tio_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic [DW-1:0]    pin_o,
	input  wire logic [DW-1:0]    pin_oe,
	input  wire logic             pull_dn_en,
	input  wire logic [DW-1:0]    ext_en,
	input  wire logic [DW-1:0]    ext_val,
	input  wire logic [NPORT-1:0] ready_val,
	input  wire logic             pclk_run,
	output logic      [DW-1:0]    pin_i,
	output logic      [NPORT-1:0] strobe_in_i
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [DW-1:0] last_q;	// Last wire level, used to spoil floating pins.
	logic [2:0]    div_q;	// Counts cycles of half a pin clock period.
	logic          pclk_q;	// Application clock sent on pin zero.

	// Wire level from every party; a released pin with no pull-down shows
	// the inverse of its last level, so reading it can never pass by luck.
	always_comb
	begin
		pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
			| (~pin_oe & ~ext_en & (pull_dn_en ? '0 : ~last_q));
		if (pclk_run)
		begin
			pin_i[0] = pclk_q;	// The pin clock overrides pin zero.
		end
	end

	// Remember the wire so that floating pins can change each cycle.
	always_ff @(posedge ref_clk)
	begin
		last_q <= pin_i;
	end

	// Pin clock toggles every five cycles and rests low between bursts.
	always_ff @(posedge ref_clk)
	begin
		if (!pclk_run)
		begin
			div_q  <= 3'h0;
			pclk_q <= 1'b0;
		end
		else if (div_q == 3'h4)
		begin
			div_q  <= 3'h0;
			pclk_q <= ~pclk_q;
		end
		else
		begin
			div_q <= div_q + 3'h1;
		end
	end

	// Ready-in is a plain level held by the attached logic.
	assign strobe_in_i = ready_val;
endmodule

// [verif/timed_io_port_clock_blocks_tb_top.sv]
// Self-checking bench for the timed I/O ports and clock blocks.
module timed_io_port_clock_blocks_tb_top
	import tio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic             ref_clk, rstn, avs_read, avs_write, avs_waitrequest;
	logic             pull_dn_en, link_en, irq, pclk_run, hit;
	logic [AW-1:0]    avs_address;
	logic [DW-1:0]    avs_writedata, avs_readdata, pin_i, pin_o, pin_oe;
	logic [DW-1:0]    ext_en, ext_val, rd, t0, w;
	logic [NPORT-1:0] strobe_in_i, strobe_out, port_event, ready_val;
	logic [7:0]       lanes[$];	// Byte lanes seen on the pins.
	logic [15:0]      v;		// Level held on the input pins.
	logic [31:0]      seed;		// State of the xorshift generator.
	int               err_count, n_tests, ns, ne;

	// The clock inverts every half period of 2 ns.
	always #2 ref_clk = ~ref_clk;

	timed_io DUT (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe(pin_oe), .pull_dn_en(pull_dn_en), .strobe_in_i(strobe_in_i),
		.strobe_out(strobe_out), .link_en(link_en),
		.port_event(port_event), .irq(irq));

	pin_partner far_side (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe),
		.pull_dn_en(pull_dn_en), .ext_en(ext_en), .ext_val(ext_val),
		.ready_val(ready_val), .pclk_run(pclk_run), .pin_i(pin_i),
		.strobe_in_i(strobe_in_i));

	// Xorshift step; a fixed seed keeps every run the same.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Lane i of a word sent least significant lane first.
	function automatic logic [31:0] lane(logic [31:0] d, int wd, int i);
		return (d >> (i * wd)) & ((32'h1 << wd) - 32'h1);
	endfunction

	// Counts the comparison and reports a mismatch at once.
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// One Avalon transfer; the request stands until the rising edge at
	// which waitrequest is seen low, and read data are taken at that edge.
	task automatic bus(logic wr, logic [AW-1:0] a, logic [DW-1:0] d);
		logic ok;
		int   waits;
		waits = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do
		begin
			@(posedge ref_clk);
			ok = (avs_waitrequest === 1'b0);
			waits += ok ? 0 : 1;
		end
		while (!ok);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
		check("wait_cycles", waits, 1);
	endtask

	// Waits a bounded time for a transfer pulse of port p.
	task automatic wait_ev(int p, int n);
		hit = 1'b0;
		for (int i = 0; i < n && !hit; i++)
		begin
			@(negedge ref_clk);
			hit = (port_event[p] === 1'b1);
		end
		@(posedge ref_clk);
	endtask

	// Disables every port so that pin ownership starts clean.
	task automatic clear_ports();
		for (int p = 0; p < NPORT; p++)
		begin
			bus(1'b1, 8'(p * 32), '0);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic end_of_test();
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// A hang is cut short well after the thousand or so cycles of the tests.
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		end_of_test();
	end

	// Main sequence.
	initial
	begin
		{ref_clk, rstn, avs_read, avs_write, link_en, pclk_run} = '0;
		{avs_address, avs_writedata, ext_en, ext_val, ready_val} = '0;
		{err_count, n_tests} = '0;
		seed = 32'h11e51c04;
		repeat (16) @(posedge ref_clk);
		check("pull_dn_reset", pull_dn_en, 1'b1);
		check("oe_reset", pin_oe, '0);
		rstn <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		check("pull_dn_run", pull_dn_en, 1'b0);
		@(posedge ref_clk);
		bus(1'b0, 8'h00, '0);
		check("ctrl_reset", rd, '0);
		bus(1'b1, 8'hf0, xs());
		bus(1'b0, 8'hf0, '0);
		check("unmapped", rd, '0);

		// Byte port with strobes: nothing moves until ready-in rises.
		w = 32'h44332211;
		bus(1'b1, IRQ_EN, '0);
		bus(1'b1, 8'h40, 32'h63);
		bus(1'b1, 8'h44, w);
		wait_ev(2, 60);
		check("held_by_ready", hit, 1'b0);
		ready_val <= 5'h04;
		{ns, ne} = '0;
		for (int i = 0; i < 60; i++)
		begin
			@(negedge ref_clk);
			if (pin_o[7:0] !== (lanes.size() ? lanes[$] : 8'h00))
				lanes.push_back(pin_o[7:0]);
			ns += strobe_out[2];
			ne += port_event[2];
		end
		check("lane_count", lanes.size(), 4);
		foreach (lanes[i]) check("lane", lanes[i], lane(w, 8, i));
		check("strobe_pulses", ns, 4);
		check("done_pulse", ne, 1);
		check("irq_masked", irq, 1'b0);
		@(posedge ref_clk);
		bus(1'b0, IRQ_STAT, '0);
		check("done_status", rd & 32'h3ff, 32'h4);
		bus(1'b1, IRQ_EN, 32'h4);
		@(negedge ref_clk);
		check("irq_on", irq, 1'b1);
		@(posedge ref_clk);
		bus(1'b1, IRQ_CLR, 32'h4);
		bus(1'b0, IRQ_STAT, '0);
		check("status_cleared", rd & 32'h3ff, '0);
		check("irq_off", irq, 1'b0);

		// Open-drain nibble port: only zero bits are driven, while a 1-bit
		// push-pull port sending ones keeps pin zero for itself.
		clear_ports();
		t0 = xs();
		bus(1'b1, 8'h00, 32'h3);
		bus(1'b1, 8'h04, 32'hffffffff);
		bus(1'b1, 8'h20, 32'h7);
		bus(1'b1, 8'h24, {t0[3:0], 28'h0});
		wait_ev(1, 200);
		check("od_done", hit, 1'b1);
		repeat (30) @(posedge ref_clk);
		check("od_pins", {pin_oe[3:0], pin_o[3:0] & pin_oe[3:0]},
			{~t0[3:1], 1'b1, 3'h0, 1'b1});

		// Input port of 16 bits: whole word, timestamp and count rate.
		clear_ports();
		t0 = xs();
		v = t0[15:0];
		ext_en <= '1;
		ext_val <= {v, v};
		bus(1'b1, 8'h60, 32'h1);
		wait_ev(3, 100);
		check("rx_done", hit, 1'b1);
		bus(1'b0, 8'h64, '0);
		check("rx_word", rd, {v, v});
		check("in_no_drive", pin_oe, '0);
		bus(1'b0, 8'h70, '0);
		t0 = rd;
		bus(1'b0, 8'h6c, '0);
		check("stamp_age", 16'(rd[15:0] - t0[15:0]) < 16'd200, 1'b1);
		t0 = rd;
		repeat (250) @(posedge ref_clk);
		bus(1'b0, 8'h6c, '0);
		w = 32'(16'(rd[15:0] - t0[15:0]));
		check("ref_rate", w >= 98 && w <= 105, 1'b1);

		// Clock block 1 fed from pin zero and divided by two.
		ext_val <= '0;
		bus(1'b1, 8'hc4, 32'h101);
		bus(1'b1, 8'h60, 32'h101);
		bus(1'b0, 8'h6c, '0);
		t0 = rd;
		pclk_run <= 1'b1;
		repeat (200) @(posedge ref_clk);
		pclk_run <= 1'b0;
		repeat (20) @(posedge ref_clk);
		bus(1'b0, 8'h6c, '0);
		check("pin_clk_count", 16'(rd[15:0] - t0[15:0]), 10);

		// Link takes pins 8..15 and a narrow input owns pins 0..7.
		clear_ports();
		bus(1'b1, 8'h40, 32'h1);
		bus(1'b1, 8'h80, 32'h3);
		link_en <= 1'b1;
		repeat (4) @(posedge ref_clk);
		w = xs();
		bus(1'b1, 8'h84, w);
		wait_ev(4, 300);
		check("wide_done", hit, 1'b1);
		repeat (4) @(posedge ref_clk);
		check("pin_owner", pin_oe, 32'hffff0000);
		check("wide_data", pin_o[31:16], w[31:16]);
		end_of_test();
	end
endmodule
